// *** rtl/acb_regs.sv ***
`timescale 1ns/1ps
module acb_regs import acb_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control port
    input acb_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    output logic hit,
    // register 108 bit 3 from elsewhere in the bank
    input wire logic page0_register_108,
    // decoded controls
    output acb_bias_t bias_out,
    output acb_chan_t chan_out
);
    logic [7:0] bias_reg;
    logic [7:0] input_reg;
    logic [7:0] gain_reg;
    logic [7:0] volume_reg;
    logic sel_bias;
    logic sel_input;
    logic sel_gain;
    logic sel_volume;
    logic [7:0] next_rdata;
    logic [2:0] bias_level;
    logic [1:0] full_scale;
    logic [1:0] source;
    logic [1:0] impedance;
    logic [5:0] gain_code;
    logic analog_src;
    // registered decodes, one flip-flop per bit
    logic bias_ref;
    logic bias_ref_x1096;
    logic bias_supply;
    logic fs_2v75;
    logic fs_2v5;
    logic fs_1v375;
    logic line_input;
    logic src_diff;
    logic src_single;
    logic src_pdm;
    logic dc_coupled;
    logic imp_2k5;
    logic imp_10k;
    logic imp_20k;
    logic range_enhancer_en;
    logic auto_gain_loop_en;
    logic gain_valid;
    logic [5:0] gain_db;
    logic [7:0] volume;

    // address decode, page 0 only
    assign sel_bias = (req.page == ACB_PAGE) && (req.addr == ACB_OFS_BIAS);
    assign sel_input = (req.page == ACB_PAGE) && (req.addr == ACB_OFS_CH_INPUT);
    assign sel_gain = (req.page == ACB_PAGE) && (req.addr == ACB_OFS_CH_GAIN);
    assign sel_volume = (req.page == ACB_PAGE) && (req.addr == ACB_OFS_CH_VOLUME);
    assign hit = sel_bias | sel_input | sel_gain | sel_volume;

    // bias and full-scale register, reserved bits held at zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bias_reg <= ACB_RST_BIAS;
        end else if (req.wr && sel_bias) begin
            bias_reg <= req.wdata & ACB_MASK_BIAS;
        end
    end

    // channel input register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            input_reg <= ACB_RST_CH_INPUT;
        end else if (req.wr && sel_input) begin
            input_reg <= req.wdata & ACB_MASK_CH_INPUT;
        end
    end

    // channel gain register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gain_reg <= ACB_RST_CH_GAIN;
        end else if (req.wr && sel_gain) begin
            gain_reg <= req.wdata & ACB_MASK_CH_GAIN;
        end
    end

    // channel volume register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            volume_reg <= ACB_RST_CH_VOLUME;
        end else if (req.wr && sel_volume) begin
            volume_reg <= req.wdata & ACB_MASK_CH_VOLUME;
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        next_rdata = 8'h00;
        if (sel_bias) begin
            next_rdata = bias_reg;
        end else if (sel_input) begin
            next_rdata = input_reg;
        end else if (sel_gain) begin
            next_rdata = gain_reg;
        end else if (sel_volume) begin
            next_rdata = volume_reg;
        end
    end

    // read data one cycle after the read request
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            if (req.rd) begin
                rdata <= next_rdata;
            end
        end
    end

    // field extraction
    assign bias_level = bias_reg[ACB_POS_BIAS_LEVEL +: 3];
    assign full_scale = bias_reg[ACB_POS_FULL_SCALE +: 2];
    assign source = input_reg[ACB_POS_SOURCE +: 2];
    assign impedance = input_reg[ACB_POS_IMPEDANCE +: 2];
    assign gain_code = gain_reg[ACB_POS_GAIN +: 6];
    assign analog_src = (source == ACB_SRC_DIFF) || (source == ACB_SRC_SINGLE);

    // bias at the reference level; reserved codes select nothing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bias_ref <= 1'b0;
        end else begin
            bias_ref <= (bias_level == ACB_BIAS_REF);
        end
    end

    // bias at the raised reference
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bias_ref_x1096 <= 1'b0;
        end else begin
            bias_ref_x1096 <= (bias_level == ACB_BIAS_REF_X1096);
        end
    end

    // bias taken straight from the analog supply
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bias_supply <= 1'b0;
        end else begin
            bias_supply <= (bias_level == ACB_BIAS_SUPPLY);
        end
    end

    // widest full-scale reference
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fs_2v75 <= 1'b0;
        end else begin
            fs_2v75 <= (full_scale == ACB_FS_2V75);
        end
    end

    // middle full-scale reference
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fs_2v5 <= 1'b0;
        end else begin
            fs_2v5 <= (full_scale == ACB_FS_2V5);
        end
    end

    // lowest full-scale reference, for low supplies
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fs_1v375 <= 1'b0;
        end else begin
            fs_1v375 <= (full_scale == ACB_FS_1V375);
        end
    end

    // line rather than microphone input
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            line_input <= 1'b0;
        end else begin
            line_input <= input_reg[ACB_POS_KIND];
        end
    end

    // differential analog source
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            src_diff <= 1'b0;
        end else begin
            src_diff <= (source == ACB_SRC_DIFF);
        end
    end

    // single-ended analog source
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            src_single <= 1'b0;
        end else begin
            src_single <= (source == ACB_SRC_SINGLE);
        end
    end

    // pulse-density microphone source
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            src_pdm <= 1'b0;
        end else begin
            src_pdm <= (source == ACB_SRC_PDM);
        end
    end

    // coupling only steers an analog input
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dc_coupled <= 1'b0;
        end else begin
            dc_coupled <= analog_src && input_reg[ACB_POS_COUPLING];
        end
    end

    // lowest impedance, analog sources only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            imp_2k5 <= 1'b0;
        end else begin
            imp_2k5 <= analog_src && (impedance == ACB_IMP_2K5);
        end
    end

    // middle impedance, analog sources only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            imp_10k <= 1'b0;
        end else begin
            imp_10k <= analog_src && (impedance == ACB_IMP_10K);
        end
    end

    // highest impedance; reserved code 3 picks none
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            imp_20k <= 1'b0;
        end else begin
            imp_20k <= analog_src && (impedance == ACB_IMP_20K);
        end
    end

    // enhancer bit hands the loop to register 108 bit 3
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            range_enhancer_en <= 1'b0;
        end else begin
            range_enhancer_en <= input_reg[ACB_POS_ENHANCER] && !page0_register_108;
        end
    end

    // gain loop takes the enhancer bit when register 108 bit 3 is set
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            auto_gain_loop_en <= 1'b0;
        end else begin
            auto_gain_loop_en <= input_reg[ACB_POS_ENHANCER] && page0_register_108;
        end
    end

    // reserved gain codes flagged as invalid
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gain_valid <= 1'b0;
        end else begin
            gain_valid <= (gain_code <= ACB_GAIN_MAX);
        end
    end

    // reserved gain codes fall back to 0 dB
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gain_db <= 6'h00;
        end else begin
            gain_db <= (gain_code <= ACB_GAIN_MAX) ? gain_code : 6'h00;
        end
    end

    // volume byte passes through untouched
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            volume <= 8'h00;
        end else begin
            volume <= volume_reg;
        end
    end

    // bias decodes gathered in struct order
    assign bias_out = {
        bias_ref,
        bias_ref_x1096,
        bias_supply,
        fs_2v75,
        fs_2v5,
        fs_1v375
    };

    // channel decodes gathered in struct order
    assign chan_out = {
        line_input,
        src_diff,
        src_single,
        src_pdm,
        dc_coupled,
        imp_2k5,
        imp_10k,
        imp_20k,
        range_enhancer_en,
        auto_gain_loop_en,
        gain_valid,
        gain_db,
        volume
    };
endmodule // acb_regs

// *** rtl/acb_pkg.sv ***
// Behaviour
// - mic bias level bits 6-4: 0 reference, 1 reference x1.096, 6 supply; rest reserved
// - full-scale select bits 1-0: 0 2.75 V, 1 2.5 V, 2 1.375 V; 3 reserved
// - input kind bit 7: 0 microphone, 1 line input; resets to 0
// - input source bits 6-5: 0 differential, 1 single-ended, 2 pulse-density; 3 reserved
// - coupling bit 4, analog only: 0 AC-coupled, 1 DC-coupled
// - impedance bits 3-2, analog only: 2.5, 10, 20 kilohm; code 3 reserved
// - enhancer bit 0: off disables both; on enables one chosen by register 108 bit 3
// - gain bits 7-2 give gain in dB for codes 0-42; 43-63 reserved
// - channel registers at page 0, 0x3c upward; first two reset to zero
// - third channel register at 0x3e resets to c9
package acb_pkg;
    // register map, page 0
    localparam logic [7:0] ACB_PAGE = 8'h00;
    localparam logic [7:0] ACB_OFS_BIAS = 8'h3b;
    localparam logic [7:0] ACB_OFS_CH_INPUT = 8'h3c;
    localparam logic [7:0] ACB_OFS_CH_GAIN = 8'h3d;
    localparam logic [7:0] ACB_OFS_CH_VOLUME = 8'h3e;
    // reset values
    localparam logic [7:0] ACB_RST_BIAS = 8'h00;
    localparam logic [7:0] ACB_RST_CH_INPUT = 8'h00;
    localparam logic [7:0] ACB_RST_CH_GAIN = 8'h00;
    localparam logic [7:0] ACB_RST_CH_VOLUME = 8'hc9;
    // writable bit masks, reserved bits cleared
    localparam logic [7:0] ACB_MASK_BIAS = 8'h73;
    localparam logic [7:0] ACB_MASK_CH_INPUT = 8'hfd;
    localparam logic [7:0] ACB_MASK_CH_GAIN = 8'hfc;
    localparam logic [7:0] ACB_MASK_CH_VOLUME = 8'hff;
    // field positions
    localparam int ACB_POS_BIAS_LEVEL = 4;
    localparam int ACB_POS_FULL_SCALE = 0;
    localparam int ACB_POS_KIND = 7;
    localparam int ACB_POS_SOURCE = 5;
    localparam int ACB_POS_COUPLING = 4;
    localparam int ACB_POS_IMPEDANCE = 2;
    localparam int ACB_POS_ENHANCER = 0;
    localparam int ACB_POS_GAIN = 2;
    localparam int ACB_POS_R108_SELECT = 3;
    // field codes
    localparam logic [2:0] ACB_BIAS_REF = 3'h0;
    localparam logic [2:0] ACB_BIAS_REF_X1096 = 3'h1;
    localparam logic [2:0] ACB_BIAS_SUPPLY = 3'h6;
    localparam logic [1:0] ACB_FS_2V75 = 2'h0;
    localparam logic [1:0] ACB_FS_2V5 = 2'h1;
    localparam logic [1:0] ACB_FS_1V375 = 2'h2;
    localparam logic [1:0] ACB_SRC_DIFF = 2'h0;
    localparam logic [1:0] ACB_SRC_SINGLE = 2'h1;
    localparam logic [1:0] ACB_SRC_PDM = 2'h2;
    localparam logic [1:0] ACB_IMP_2K5 = 2'h0;
    localparam logic [1:0] ACB_IMP_10K = 2'h1;
    localparam logic [1:0] ACB_IMP_20K = 2'h2;
    localparam logic [5:0] ACB_GAIN_MAX = 6'h2a;

    // control port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } acb_req_t;

    // decoded bias and reference selects
    typedef struct packed {
        logic bias_ref;
        logic bias_ref_x1096;
        logic bias_supply;
        logic fs_2v75;
        logic fs_2v5;
        logic fs_1v375;
    } acb_bias_t;

    // decoded channel controls
    typedef struct packed {
        logic line_input;
        logic src_diff;
        logic src_single;
        logic src_pdm;
        logic dc_coupled;
        logic imp_2k5;
        logic imp_10k;
        logic imp_20k;
        logic range_enhancer_en;
        logic auto_gain_loop_en;
        logic gain_valid;
        logic [5:0] gain_db;
        logic [7:0] volume;
    } acb_chan_t;
endpackage

// *** tb/acb_regs_properties.sv ***
`timescale 1ns/1ps
module acb_regs_chk import acb_pkg::*; (
    // watched ports
    input wire logic clk,
    input wire logic rst_n,
    input acb_req_t req,
    input logic [7:0] rdata,
    input logic rvalid,
    input logic hit,
    input wire logic page0_register_108,
    input acb_bias_t bias_out,
    input acb_chan_t chan_out
);
    // writes that hit the bias, input and gain registers
    logic w_bias, w_in, w_gain;
    assign w_bias = req.wr && hit && req.addr == ACB_OFS_BIAS;
    assign w_in = req.wr && hit && req.addr == ACB_OFS_CH_INPUT;
    assign w_gain = req.wr && hit && req.addr == ACB_OFS_CH_GAIN;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_read_answers: assert property (req.rd |=> rvalid) else $error("no answer");
    a_map_decode: assert property (hit == (req.page == ACB_PAGE &&
        req.addr >= ACB_OFS_BIAS && req.addr <= ACB_OFS_CH_VOLUME)) else $error("bad hit");
    a_unmapped_zero: assert property (req.rd && !hit |=> rdata == 8'h00)
        else $error("unmapped data");
    a_gain_low_bits: assert property (req.rd && hit && req.addr == ACB_OFS_CH_GAIN
        |=> rdata[1:0] == 2'h0) else $error("reserved bits set");
    a_kind_follows: assert property (w_in |-> ##2
        chan_out.line_input == $past(req.wdata[7], 2)) else $error("kind wrong");
    a_gain_range: assert property (w_gain |-> ##2
        chan_out.gain_valid == ($past(req.wdata[7:2], 2) <= 6'h2a)) else $error("gain");
    a_bias_supply: assert property (w_bias |-> ##2
        bias_out.bias_supply == ($past(req.wdata[6:4], 2) == 3'h6)) else $error("bias");
    a_fs_low: assert property (w_bias |-> ##2
        bias_out.fs_1v375 == ($past(req.wdata[1:0], 2) == 2'h2)) else $error("scale");
    a_enh_off: assert property (w_in && !req.wdata[0] |-> ##2
        !(chan_out.range_enhancer_en || chan_out.auto_gain_loop_en)) else $error("enh");
endmodule // acb_regs_chk

bind acb_regs acb_regs_chk u_chk (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .rvalid(rvalid), .hit(hit), .page0_register_108(page0_register_108),
    .bias_out(bias_out), .chan_out(chan_out));

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb import acb_pkg::*; ();
    // stimulus and observed signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic page0_register_108 = 1'b0;
    acb_req_t req = '0;
    logic [7:0] rdata;
    logic rvalid, hit;
    acb_bias_t bias_out;
    acb_chan_t chan_out;
    int mismatches = 0;
    int n_checks = 0;
    logic [7:0] msk [4] = '{8'h73, 8'hfd, 8'hfc, 8'hff};
    logic [5:0] gains [4] = '{6'h00, 6'h2a, 6'h2b, 6'h3f};
    always #12.5 clk = ~clk;
    acb_regs u_dut (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .rvalid(rvalid),
        .hit(hit), .page0_register_108(page0_register_108), .bias_out(bias_out),
        .chan_out(chan_out));
    // compare and count
    task automatic chk(input string what, input logic [24:0] seen, input logic [24:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // one write strobe, taken at the second edge
    task automatic wr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, page: pg, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask
    // one read strobe, answer checked one cycle later
    task automatic rd(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, page: pg, addr: a, wdata: 8'h00};
        #1;
        chk("hit", 25'(hit), 25'(pg == ACB_PAGE && a >= ACB_OFS_BIAS
            && a <= ACB_OFS_CH_VOLUME));
        @(posedge clk);
        req <= '0;
        #1;
        chk("rvalid", 25'(rvalid), 25'h1);
        chk("rdata", 25'(rdata), 25'(exp));
    endtask
    // let decoded outputs follow the register
    task automatic settle;
        @(posedge clk);
        #1;
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h00, 8'h3c, 8'h00);
        rd(8'h00, 8'h3d, 8'h00);
        rd(8'h00, 8'h3e, 8'hc9);
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, 8'h3b + 8'(i), 8'hff);
            rd(8'h00, 8'h3b + 8'(i), msk[i]);
        end
        rd(8'h00, 8'h3f, 8'h00);
        wr(8'h01, 8'h3e, 8'h00);
        rd(8'h01, 8'h3e, 8'h00);
        rd(8'h00, 8'h3e, 8'hff);
        chk("volume", 25'(chan_out.volume), 25'hff);
        for (int b = 0; b < 8; b++) begin
            wr(8'h00, 8'h3b, {1'b0, 3'(b), 2'b00, 2'(b)});
            settle();
            chk("bias", 25'(bias_out[5:3]), 25'({b == 0, b == 1, b == 6}));
            chk("scale", 25'(bias_out[2:0]), 25'({b % 4 == 0, b % 4 == 1, b % 4 == 2}));
        end
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            page0_register_108 <= s[1];
            wr(8'h00, 8'h3c, {s[0], 2'(s), 1'b1, 2'(s), 2'b01});
            settle();
            chk("kind", 25'(chan_out.line_input), 25'(s[0]));
            chk("src", 25'(chan_out[23:21]), 25'({s == 0, s == 1, s == 2}));
            chk("dc", 25'(chan_out.dc_coupled), 25'(s < 2));
            chk("imp", 25'(chan_out[19:17]), 25'({s == 0, s == 1, 1'b0}));
            chk("enh", 25'(chan_out[16:15]), 25'({~s[1], s[1]}));
        end
        wr(8'h00, 8'h3c, 8'h08);
        settle();
        chk("enh", 25'(chan_out[16:15]), 25'h0);
        chk("imp", 25'(chan_out[19:17]), 25'h1);
        chk("dc", 25'(chan_out.dc_coupled), 25'h0);
        foreach (gains[i]) begin
            wr(8'h00, 8'h3d, {gains[i], 2'b11});
            rd(8'h00, 8'h3d, {gains[i], 2'b00});
            chk("gain", 25'(chan_out[14:8]),
                25'(gains[i] <= 6'h2a ? {1'b1, gains[i]} : 7'h0));
        end
        // a mid-run reset brings back the defaults
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h00, 8'h3e, 8'hc9);
        rd(8'h00, 8'h3c, 8'h00);
        chk("scale", 25'(bias_out[2:0]), 25'h4);
        chk("gain", 25'(chan_out[14:8]), 25'h40);
        summarize();
    end
    // hang guard
    initial begin
        repeat (2000) @(posedge clk);
        mismatches++;
        summarize();
    end
endmodule // tb
